// [test/pace_resp_monitor.sv]
`timescale 1ns/1ps
module pace_resp_monitor
(
  // APB side
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire        pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Configuration outputs
  input wire [1:0]  carrier_freq_select,
  input wire        alt_freq_mode,
  input wire        breath_measure_enable,
  input wire        pulse_width_filter_en,
  input wire        validation_filter_two_en,
  input wire        validation_filter_one_en,
  input wire [1:0]  detector_three_lead_sel,
  input wire [1:0]  detector_two_lead_sel,
  input wire [1:0]  detector_one_lead_sel,
  input wire        detector_three_enable,
  input wire        detector_two_enable,
  input wire        detector_one_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes per register
  wire pw = psel && penable && pwrite && paddr == 12'h010;
  wire rw = psel && penable && pwrite && paddr == 12'h00c;
  a_width_filt_wr: assert property (pw |=> pulse_width_filter_en == $past(pwdata[11]))
    else $error("width filter not loaded");
  a_filt_two_wr: assert property (pw |=> validation_filter_two_en == $past(pwdata[10]))
    else $error("filter two not loaded");
  a_filt_one_wr: assert property (pw |=> validation_filter_one_en == $past(pwdata[9]))
    else $error("filter one not loaded");
  a_lead_sel_wr: assert property (pw |=> {detector_three_lead_sel, detector_two_lead_sel,
    detector_one_lead_sel} == $past(pwdata[8:3])) else $error("lead select not loaded");
  a_det_en_wr: assert property (pw |=> {detector_three_enable, detector_two_enable,
    detector_one_enable} == $past(pwdata[2:0])) else $error("detector enables not loaded");
  a_det_reset_off: assert property ($rose(presetn) |-> !detector_one_enable &&
    !detector_two_enable && !detector_three_enable) else $error("detector on after reset");
  a_resp_en_wr: assert property (rw |=> breath_measure_enable == $past(pwdata[0]))
    else $error("respiration enable not loaded");
  a_freq_sel_wr: assert property (rw |=> carrier_freq_select == $past(pwdata[2:1]))
    else $error("carrier code not loaded");
  a_pace_rsv_zero: assert property (psel && penable && !pwrite && paddr == 12'h010
    |-> prdata[23:12] == 12'h000) else $error("reserved pace bits nonzero");
  c_pace_wr: cover property (pw);
  c_resp_wr: cover property (rw);
  a_alt_mode_wr: assert property (rw |=> alt_freq_mode == $past(pwdata[16]))
    else $error("alternate table bit not loaded");
  a_resp_reset_off: assert property ($rose(presetn) |-> !breath_measure_enable)
    else $error("respiration on after reset");
  a_pace_reset_cfg: assert property ($rose(presetn) |->
    pulse_width_filter_en && validation_filter_two_en && validation_filter_one_en &&
    detector_three_lead_sel == 2'b11 && detector_two_lead_sel == 2'b00 &&
    detector_one_lead_sel == 2'b01) else $error("pace defaults wrong after reset");
  a_unmapped_err: assert property (psel && penable |-> pslverr == (paddr != 12'h00c &&
    paddr != 12'h010)) else $error("error response wrong");
  c_reset_rel: cover property ($rose(presetn));
  c_unmapped: cover property (psel && penable && pslverr);
endmodule
bind pace_resp_control_regs pace_resp_monitor mon
(
  .pclk                     (pclk),
  .presetn                  (presetn),
  .psel                     (psel),
  .penable                  (penable),
  .pwrite                   (pwrite),
  .pready                   (pready),
  .pslverr                  (pslverr),
  .paddr                    (paddr),
  .pwdata                   (pwdata),
  .prdata                   (prdata),
  .carrier_freq_select      (carrier_freq_select),
  .alt_freq_mode            (alt_freq_mode),
  .breath_measure_enable    (breath_measure_enable),
  .pulse_width_filter_en    (pulse_width_filter_en),
  .validation_filter_two_en (validation_filter_two_en),
  .validation_filter_one_en (validation_filter_one_en),
  .detector_three_lead_sel  (detector_three_lead_sel),
  .detector_two_lead_sel    (detector_two_lead_sel),
  .detector_one_lead_sel    (detector_one_lead_sel),
  .detector_three_enable    (detector_three_enable),
  .detector_two_enable      (detector_two_enable),
  .detector_one_enable      (detector_one_enable)
);

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic [1:0]  carrier_freq_select, detector_three_lead_sel, detector_two_lead_sel;
  logic [1:0]  detector_one_lead_sel;
  logic        alt_freq_mode, breath_measure_enable, pulse_width_filter_en;
  logic        validation_filter_two_en, validation_filter_one_en, detector_three_enable;
  logic        detector_two_enable, detector_one_enable;
  logic [31:0] q[$];
  int          bad_count = 0, checks = 0, n;
  pace_resp_control_regs DUT
  (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .carrier_freq_select      (carrier_freq_select),
    .alt_freq_mode            (alt_freq_mode),
    .breath_measure_enable    (breath_measure_enable),
    .pulse_width_filter_en    (pulse_width_filter_en),
    .validation_filter_two_en (validation_filter_two_en),
    .validation_filter_one_en (validation_filter_one_en),
    .detector_three_lead_sel  (detector_three_lead_sel),
    .detector_two_lead_sel    (detector_two_lead_sel),
    .detector_one_lead_sel    (detector_one_lead_sel),
    .detector_three_enable    (detector_three_enable),
    .detector_two_enable      (detector_two_enable),
    .detector_one_enable      (detector_one_enable)
  );
  always #25 pclk = ~pclk;
  // Count a compare, report a miss
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin bad_count++; $display("wrong value prdata exp %h seen %h", e, s); end
  endtask
  task close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer; reads note their expected word, wait bounded
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, e);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    if (!w) q.push_back(e);
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; close_out; end
    {psel, penable} <= 2'b00;
  endtask
  // Completed reads against the oldest note
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
      chk(prdata, q.pop_front());
  // Second pass follows a mid-run reset with dirty registers
  initial
  begin
    void'($urandom(92237));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (int t = 0; t < 2; t++)
    begin
      if (t == 1) begin @(posedge pclk) presetn <= 0; @(posedge pclk) presetn <= 1; end
      xfer(0, 12'h00c, 0, 0);
      xfer(0, 12'h010, 0, 32'hf88);
      xfer(1, 12'h014, '1, 0);
      xfer(0, 12'h014, 0, 0);
      for (int i = 0; i < 10; i++)
      begin
        d = i < 2 ? {32{i[0]}} : $urandom;
        xfer(1, 12'h010, d & 32'hff000fff, 0); // reserved bits written as zero
        xfer(0, 12'h010, 0, d & 32'h00000fff);
        xfer(1, 12'h00c, d, 0);
        xfer(0, 12'h00c, 0, d & 32'h00010007);
      end
      $display("test %0d done", t);
    end
    repeat (2) @(posedge pclk);
    close_out;
  end
endmodule

// [verilog/pace_resp_control_regs.v]
`timescale 1ns/1ps
`include "pace_resp_defs.vh"
module pace_resp_control_regs
(
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Respiration configuration
  output wire [1:0]  carrier_freq_select,
  output wire        alt_freq_mode,
  output wire        breath_measure_enable,
  // Pace detection configuration
  output wire        pulse_width_filter_en,
  output wire        validation_filter_two_en,
  output wire        validation_filter_one_en,
  output wire [1:0]  detector_three_lead_sel,
  output wire [1:0]  detector_two_lead_sel,
  output wire [1:0]  detector_one_lead_sel,
  output wire        detector_three_enable,
  output wire        detector_two_enable,
  output wire        detector_one_enable
);

  // Pace detector count; each owns one selector pair and one enable
  localparam        detector_count  = 3;

  // Reset images: respiration full width, pace only its owned 12 bits; only the owned slices are loaded
  localparam [23:0] resp_reset_full = `RESP_RESET;
  localparam [11:0] pace_reset_kept = `PACE_RESET;

  // Word indexes widened to the decoded address slice
  localparam [9:0]  resp_index      = {2'b00, `RESP_CTRL_IDX};
  localparam [9:0]  pace_index      = {2'b00, `PACE_CTRL_IDX};

  // Respiration fields owned here; the rest of that word lives elsewhere
  reg         resp_en_reg;      // Respiration enable, bit 0
  reg         resp_en_next;     // Its next value
  reg  [1:0]  resp_freq_reg;    // Carrier frequency code, bits 2:1
  reg  [1:0]  resp_freq_next;   // Its next value
  reg         resp_alt_reg;     // Alternate frequency table, bit 16
  reg         resp_alt_next;    // Its next value

  // Pace control fields, bits 11:0; bits 23:12 are never stored
  reg  [11:0] pace_reg;         // Filters, lead selectors, enables
  reg  [11:0] pace_next;        // Its next value

  // Address decode and transfer qualifiers
  wire [9:0]  word_index;       // Word index from the byte address
  wire        aligned;          // Low address bits clear
  reg         hit_resp;         // Respiration word addressed
  reg         hit_pace;         // Pace word addressed
  wire        access;           // Access phase of any transfer
  wire        wr_resp;          // Write lands in respiration word
  wire        wr_pace;          // Write lands in pace word
  wire        rd_setup;         // Read setup cycle, data captured here
  reg  [31:0] rd_word;          // Read image of the addressed word

  // Per-detector fields gathered by the generate loop
  wire [5:0]  lead_sel_bus;     // Lead selectors, detector one lowest
  wire [2:0]  det_en_bus;       // Detector enables, detector one lowest
  genvar      det;              // Detector number in the loop

  // Byte address to word index
  assign word_index = paddr[11:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign access     = psel & penable;

  // Address decode; misaligned addresses match no register
  always @*
  begin
    hit_resp = 1'b0;
    hit_pace = 1'b0;
    if (!aligned)
    begin
      // Part-word addresses are treated as unmapped
      hit_resp = 1'b0;
      hit_pace = 1'b0;
    end
    else if (word_index == resp_index)
      hit_resp = 1'b1;
    else if (word_index == pace_index)
      hit_pace = 1'b1;
  end

  // Write strobes land only in the access phase
  assign wr_resp  = access & pwrite & hit_resp;
  assign wr_pace  = access & pwrite & hit_pace;
  // Read data captured a cycle early so it stands through access
  assign rd_setup = psel & ~penable & ~pwrite;

  // Zero wait state; unmapped or misaligned accesses report an error
  assign pready  = 1'b1;
  assign pslverr = access & ~(hit_resp | hit_pace);

  // Next respiration fields; untouched unless this word is written
  always @*
  begin
    resp_en_next   = resp_en_reg;
    resp_freq_next = resp_freq_reg;
    resp_alt_next  = resp_alt_reg;
    if (wr_resp)
    begin
      // Bits 15:3 and 23:17 belong to other blocks and are dropped
      resp_en_next   = pwdata[`RESP_EN_BIT];
      resp_freq_next = pwdata[`RESP_FREQ_MSB:`RESP_FREQ_LSB];
      resp_alt_next  = pwdata[`RESP_ALT_BIT];
    end
  end

  // Next pace fields; reserved upper bits never reach storage
  always @*
  begin
    pace_next = pace_reg;
    if (wr_pace)
    begin
      // No byte strobes: a write replaces every owned pace field
      pace_next = pwdata[`PACE_USED_MSB:0];
    end
  end

  // Respiration storage; reset leaves respiration off
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      resp_en_reg   <= resp_reset_full[`RESP_EN_BIT];
      resp_freq_reg <= resp_reset_full[`RESP_FREQ_MSB:`RESP_FREQ_LSB];
      resp_alt_reg  <= resp_reset_full[`RESP_ALT_BIT];
    end
    else
    begin
      // Next values already hold the old fields when not written
      resp_en_reg   <= resp_en_next;
      resp_freq_reg <= resp_freq_next;
      resp_alt_reg  <= resp_alt_next;
    end
  end

  // Pace storage; filters on, detectors off after reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pace_reg <= pace_reset_kept;
    else
      pace_reg <= pace_next;
  end

  // Read image; fields not owned here read as zero
  always @*
  begin
    rd_word = 32'h00000000;
    if (hit_resp)
    begin
      rd_word[`RESP_EN_BIT]                  = resp_en_reg;
      rd_word[`RESP_FREQ_MSB:`RESP_FREQ_LSB] = resp_freq_reg;
      rd_word[`RESP_ALT_BIT]                 = resp_alt_reg;
    end
    else if (hit_pace)
    begin
      // Bits 23:12 keep their zero default
      rd_word[`PACE_USED_MSB:0] = pace_reg;
    end
    else
    begin
      // Unmapped or misaligned words read as zero
      rd_word = 32'h00000000;
    end
  end

  // Read data register; loaded in setup, held until the next read
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_setup)
    begin
      // A write in between cannot disturb data already captured
      prdata <= rd_word;
    end
  end

  // One field group per detector: two selector bits and one enable
  generate
    for (det = 0; det < detector_count; det = det + 1)
    begin : detector_field
      // Selector pairs step by two from the lowest selector
      assign lead_sel_bus[2*det+1:2*det] =
             pace_reg[`PACE_SEL1_LSB+2*det+1:`PACE_SEL1_LSB+2*det];
      // Enables sit in consecutive bits from the lowest enable
      assign det_en_bus[det] = pace_reg[`PACE_EN1_BIT+det];
    end
  endgenerate

  // Respiration outputs straight from storage
  assign breath_measure_enable    = resp_en_reg;
  assign carrier_freq_select      = resp_freq_reg;
  assign alt_freq_mode            = resp_alt_reg;

  // Pace filter outputs straight from storage
  assign pulse_width_filter_en    = pace_reg[`PACE_FILTW_BIT];
  assign validation_filter_two_en = pace_reg[`PACE_FILT2_BIT];
  assign validation_filter_one_en = pace_reg[`PACE_FILT1_BIT];

  // Lead selectors unpacked, detector one in the lowest pair
  assign detector_one_lead_sel    = lead_sel_bus[1:0];
  assign detector_two_lead_sel    = lead_sel_bus[3:2];
  assign detector_three_lead_sel  = lead_sel_bus[5:4];

  // Detector enables unpacked, detector one in the lowest bit
  assign detector_one_enable      = det_en_bus[0];
  assign detector_two_enable      = det_en_bus[1];
  assign detector_three_enable    = det_en_bus[2];

endmodule

// [verilog/pace_resp_defs.vh]
`ifndef PACE_RESP_DEFS_VH
`define PACE_RESP_DEFS_VH
// Register indexes (byte address is four times the index)
`define RESP_CTRL_IDX        8'h03
`define PACE_CTRL_IDX        8'h04
// Respiration control fields
`define RESP_EN_BIT          0
`define RESP_FREQ_LSB        1
`define RESP_FREQ_MSB        2
`define RESP_ALT_BIT         16
`define RESP_USED_MSB        16
`define RESP_RESET           24'h000000
// Pace control fields
`define PACE_EN1_BIT         0
`define PACE_EN3_BIT         2
`define PACE_SEL1_LSB        3
`define PACE_SEL3_MSB        8
`define PACE_FILT1_BIT       9
`define PACE_FILT2_BIT       10
`define PACE_FILTW_BIT       11
`define PACE_USED_MSB        11
`define PACE_RESET           12'hf88
`endif
